// ### power_save_defs.vh
`ifndef POWER_SAVE_DEFS_VH
`define POWER_SAVE_DEFS_VH

// Register byte addresses
`define ADDR_SLOW_IDLE_CTRL   12'h028C
`define ADDR_WAKE_CFG         12'h0290
`define ADDR_POWER_STATUS     12'h0294

// Control register fields
`define CTRL_IDLE_SELECT_BIT  7
`define CTRL_SLOW_EN_BIT      6
`define CTRL_RECOVER_BIT      5
`define CTRL_SLOW_EXIT_BIT    4
`define CTRL_RATIO_MSB        2
`define CTRL_RATIO_LSB        0
`define CTRL_RESET            8'h00
`define CTRL_WRITE_MASK       8'hF7

// Wake configuration fields
`define CFG_WATCHDOG_SLEEP_BIT 0
`define CFG_BROWNOUT_OFF_BIT   1
`define CFG_CRYSTAL_MODE_BIT   2
`define CFG_CLOCK_OUT_EN_BIT   3
`define CFG_RESET              4'h8

// Status fields
`define STAT_POWERDOWN_BIT    0
`define STAT_TIMEOUT_BIT      1
`define STAT_SLEEP_BIT        2
`define STAT_IDLE_BIT         3
`define STAT_WAKE_WAIT_BIT    4

// Oscillator start-up delay in oscillator periods
`define STARTUP_PERIODS       1024
`define STARTUP_CYCLES        11'h400
`define STARTUP_CNT_W         11

// Slow-CPU divider counter width (largest ratio 1:256)
`define RATIO_CNT_W           8

`endif

// ### slow_step_divider.v
`default_nettype none

module slow_step_divider #(
  parameter CNT_W = 8
) (
  input  wire             ref_clk_i,
  input  wire             nrst_i,
  input  wire             enable_i,
  input  wire [2:0]       ratio_i,
  output reg              tick_o
);

  reg  [CNT_W-1:0] cnt_ff;
  wire [CNT_W-1:0] last_cnt;
  wire [CNT_W-1:0] nxt_cnt;

  // Ratio code k gives one step in every 2^(k+1) cycles
  // Shift amount is four bits wide so code 7 reaches 8; the wrap to zero then gives all ones
  assign last_cnt = ({{(CNT_W-1){1'b0}}, 1'b1} << ({1'b0, ratio_i} + 4'h1))
                    - {{(CNT_W-1){1'b0}}, 1'b1};
  assign nxt_cnt  = (cnt_ff >= last_cnt) ? {CNT_W{1'b0}} : cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (!enable_i)
    begin
      // Restart so the first slow step comes right after enabling
      cnt_ff <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_o <= (cnt_ff == {CNT_W{1'b0}});
    end
  end

endmodule

`default_nettype wire

// ### sleep_idle_doze_control.v
// Overview of operation
// - Sleep instruction, idle-select clear: full Sleep
// - Clear watchdog on Sleep; runs if enabled
// - Sleep entry clears powerdown, sets timeout flag
// - Other oscillators keep running in Sleep
// - I/O ports hold their state in Sleep
// - Non-watchdog resets keep working in Sleep
// - Reset sources reset; interrupts continue execution
// - Only enabled interrupts wake, ignoring global enable
// - Global enable decides resume or service call
// - Watchdog cleared on every Sleep wake-up
// - Wait flash, clock, brown-out ready before run
// - Pending interrupt makes sleep a no-operation
// - Interrupt during sleep: complete, wake at once
// - Crystal mode waits 1024-period start-up delay
// - Idle-select set: Idle halts CPU, peripherals run
// - System clock stopped only in Sleep
// - Clock output keeps toggling in Idle while the clock-out enable bit is clear
// - Interrupt ends Idle; may restore full speed
// - Watchdog in Idle wakes, slow enable unchanged
// - Recover bit clears slow enable on service entry
// - Slow-on-exit sets slow enable on service return
// - Ratio field selects 1:2 up to 1:256
// - Slow CPU executes one cycle in N
//
// The Avalon-MM interface to the registers was left to the implementer.
`include "power_save_defs.vh"
`default_nettype none

module sleep_idle_doze_control #(
  parameter INT_W       = 8,
  parameter CLK_SW_INT  = 3
) (
  input  wire             ref_clk_i,
  input  wire             nrst_i,
  // Avalon-MM slave
  input  wire [11:0]      avs_address_i,
  input  wire             avs_read_i,
  input  wire             avs_write_i,
  input  wire [31:0]      avs_writedata_i,
  input  wire [3:0]       avs_byteenable_i,
  output reg  [31:0]      avs_readdata_o,
  output wire             avs_waitrequest_o,
  // CPU core
  input  wire             sleep_exec_i,
  input  wire             global_int_enable_i,
  input  wire [INT_W-1:0] int_flags_i,
  input  wire [INT_W-1:0] periph_int_enable_regs_i,
  input  wire             isr_entry_i,
  input  wire             isr_exit_i,
  output reg              cpu_step_o,
  output reg              resume_o,
  output reg              isr_call_o,
  output reg              sleep_nop_o,
  // Readiness
  input  wire             program_flash_ready_i,
  input  wire             sysclk_ready_i,
  input  wire             brownout_ready_i,
  // Reset pins
  input  wire             external_reset_pin_n_i,
  input  wire             brownout_reset_i,
  input  wire             low_power_brownout_reset_i,
  input  wire             power_on_reset_i,
  output reg              device_reset_o,
  // Watchdog
  input  wire             watchdog_timeout_i,
  output reg              watchdog_clear_o,
  output reg              watchdog_run_o,
  // Clocks and pins
  output reg              sysclk_run_o,
  output reg              aux_osc_run_o,
  output reg              io_hold_o,
  output reg              clock_output_pin_o,
  output reg              sleep_mode_o,
  output reg              idle_mode_o
);

  localparam [1:0] ST_RUN  = 2'd0;
  localparam [1:0] ST_SLP  = 2'd1;
  localparam [1:0] ST_IDL  = 2'd2;
  localparam [1:0] ST_WAKE = 2'd3;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  nxt_ctrl;
  reg  [3:0]  cfg_ff;
  reg         powerdown_flag_ff;
  reg         timeout_flag_ff;
  reg  [10:0] startup_cnt_ff;
  reg  [3:0]  rst_meta_ff;
  reg  [3:0]  rst_sync_ff;
  reg         ack_ff;
  reg  [1:0]  clock_output_pin_div_ff;
  reg  [31:0] nxt_rdata;
  reg         wake_int;
  reg         enter_sleep;
  reg         enter_idle;
  reg         sleep_wake;
  reg         wake_done;

  wire        slow_tick;
  wire        req;
  wire        wr_ctrl;
  wire        wr_cfg;
  wire        any_reset;
  wire        int_pending;
  wire        wake_ready;
  wire [INT_W-1:0] wake_mask;

  wire idle_select          = ctrl_ff[`CTRL_IDLE_SELECT_BIT];
  wire slow_cpu_enable      = ctrl_ff[`CTRL_SLOW_EN_BIT];
  wire recover_on_interrupt = ctrl_ff[`CTRL_RECOVER_BIT];
  wire slow_on_isr_exit     = ctrl_ff[`CTRL_SLOW_EXIT_BIT];
  wire watchdog_in_sleep    = cfg_ff[`CFG_WATCHDOG_SLEEP_BIT];
  wire brownout_off         = cfg_ff[`CFG_BROWNOUT_OFF_BIT];
  wire crystal_mode         = cfg_ff[`CFG_CRYSTAL_MODE_BIT];
  wire clock_out_enable     = cfg_ff[`CFG_CLOCK_OUT_EN_BIT];

  // Clock-switch interrupt never wakes the part
  genvar gi;
  generate
    for (gi = 0; gi < INT_W; gi = gi + 1)
    begin : g_wake_mask
      assign wake_mask[gi] = (gi != CLK_SW_INT);
    end
  endgenerate

  assign int_pending = |(int_flags_i & periph_int_enable_regs_i & wake_mask);

  // Reset pins come from outside: two flops before any use
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_ff <= 4'h0;
      rst_sync_ff <= 4'h0;
    end
    else
    begin
      rst_meta_ff <= {~external_reset_pin_n_i, brownout_reset_i,
                      low_power_brownout_reset_i, power_on_reset_i};
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // A watchdog expiry resets in every state but Idle; in Idle it wakes instead
  assign any_reset = (|rst_sync_ff) || (watchdog_timeout_i && state_ff != ST_IDL);

  assign wake_ready = program_flash_ready_i && sysclk_ready_i
                      && (brownout_ready_i || brownout_off)
                      && (startup_cnt_ff == 11'h000);

  // Bus handshake: every access waits exactly one cycle
  assign req               = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_ff;
  assign wr_ctrl = avs_write_i && ack_ff && avs_byteenable_i[0]
                   && (avs_address_i == `ADDR_SLOW_IDLE_CTRL);
  assign wr_cfg  = avs_write_i && ack_ff && avs_byteenable_i[0]
                   && (avs_address_i == `ADDR_WAKE_CFG);

  slow_step_divider #(
    .CNT_W     (`RATIO_CNT_W)
  ) u_slow_div (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .enable_i  (slow_cpu_enable && state_ff == ST_RUN),
    .ratio_i   (ctrl_ff[`CTRL_RATIO_MSB:`CTRL_RATIO_LSB]),
    .tick_o    (slow_tick)
  );

  // Mode sequencing
  always @*
  begin
    nxt_state   = state_ff;
    wake_int    = 1'b0;
    enter_sleep = 1'b0;
    enter_idle  = 1'b0;
    sleep_wake  = 1'b0;
    wake_done   = 1'b0;
    case (state_ff)
      ST_RUN:
      begin
        if (sleep_exec_i && !int_pending)
        begin
          if (idle_select)
          begin
            enter_idle = 1'b1;
            nxt_state  = ST_IDL;
          end
          else
          begin
            enter_sleep = 1'b1;
            nxt_state   = ST_SLP;
          end
        end
      end
      ST_SLP:
      begin
        // An interrupt raised during the instruction lands here and wakes at once
        if (int_pending)
        begin
          sleep_wake = 1'b1;
          wake_int   = 1'b1;
          nxt_state  = ST_WAKE;
        end
      end
      ST_IDL:
      begin
        if (int_pending)
        begin
          wake_int  = 1'b1;
          nxt_state = ST_RUN;
        end
        else if (watchdog_timeout_i)
        begin
          nxt_state = ST_RUN;
        end
      end
      ST_WAKE:
      begin
        if (wake_ready)
        begin
          wake_done = 1'b1;
          nxt_state = ST_RUN;
        end
      end
      default:
      begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // Control register: hardware updates win over a same-cycle software write
  always @*
  begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl)
    begin
      nxt_ctrl = avs_writedata_i[7:0] & `CTRL_WRITE_MASK;
    end
    if (state_ff == ST_IDL && wake_int && recover_on_interrupt && slow_cpu_enable)
    begin
      nxt_ctrl[`CTRL_SLOW_EN_BIT] = 1'b0;
    end
    if (isr_entry_i && recover_on_interrupt)
    begin
      nxt_ctrl[`CTRL_SLOW_EN_BIT] = 1'b0;
    end
    else if (isr_exit_i && slow_on_isr_exit)
    begin
      nxt_ctrl[`CTRL_SLOW_EN_BIT] = 1'b1;
    end
  end

  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_i)
      `ADDR_SLOW_IDLE_CTRL: nxt_rdata[7:0] = ctrl_ff;
      `ADDR_WAKE_CFG:       nxt_rdata[3:0] = cfg_ff;
      `ADDR_POWER_STATUS:
      begin
        nxt_rdata[`STAT_POWERDOWN_BIT] = powerdown_flag_ff;
        nxt_rdata[`STAT_TIMEOUT_BIT]   = timeout_flag_ff;
        nxt_rdata[`STAT_SLEEP_BIT]     = (state_ff == ST_SLP);
        nxt_rdata[`STAT_IDLE_BIT]      = (state_ff == ST_IDL);
        nxt_rdata[`STAT_WAKE_WAIT_BIT] = (state_ff == ST_WAKE);
      end
      default:              nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_ff         <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= req && !ack_ff;
      if (avs_read_i && !ack_ff)
      begin
        avs_readdata_o <= nxt_rdata;
      end
    end
  end

  // Registers, flags and state
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff          <= ST_RUN;
      ctrl_ff           <= `CTRL_RESET;
      cfg_ff            <= `CFG_RESET;
      powerdown_flag_ff <= 1'b1;
      timeout_flag_ff   <= 1'b1;
      startup_cnt_ff    <= 11'h000;
    end
    else if (any_reset)
    begin
      // A device reset restarts the core; wake configuration survives
      state_ff          <= ST_RUN;
      ctrl_ff           <= `CTRL_RESET;
      powerdown_flag_ff <= 1'b1;
      timeout_flag_ff   <= !watchdog_timeout_i;
      startup_cnt_ff    <= 11'h000;
    end
    else
    begin
      state_ff <= nxt_state;
      ctrl_ff  <= nxt_ctrl;
      if (wr_cfg)
      begin
        cfg_ff <= avs_writedata_i[3:0];
      end
      // Flags untouched when the instruction falls through as a no-operation
      if (enter_sleep || enter_idle)
      begin
        powerdown_flag_ff <= 1'b0;
        timeout_flag_ff   <= 1'b1;
      end
      if (sleep_wake && crystal_mode)
      begin
        startup_cnt_ff <= `STARTUP_CYCLES;
      end
      else if (startup_cnt_ff != 11'h000)
      begin
        startup_cnt_ff <= startup_cnt_ff - 11'h001;
      end
    end
  end

  // Outputs toward core, watchdog and pads
  always @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cpu_step_o         <= 1'b0;
      resume_o           <= 1'b0;
      isr_call_o         <= 1'b0;
      sleep_nop_o        <= 1'b0;
      device_reset_o     <= 1'b1;
      watchdog_clear_o   <= 1'b1;
      watchdog_run_o     <= 1'b0;
      sysclk_run_o       <= 1'b1;
      aux_osc_run_o      <= 1'b1;
      io_hold_o          <= 1'b0;
      clock_output_pin_o <= 1'b0;
      clock_output_pin_div_ff      <= 2'b00;
      sleep_mode_o       <= 1'b0;
      idle_mode_o        <= 1'b0;
    end
    else
    begin
      device_reset_o <= any_reset;
      cpu_step_o     <= !any_reset && nxt_state == ST_RUN && state_ff == ST_RUN
                        && (!slow_cpu_enable || slow_tick);
      sleep_nop_o    <= state_ff == ST_RUN && sleep_exec_i && int_pending;
      // Interrupt wake resumes the core; the service call comes in the same cycle if enabled
      resume_o       <= !any_reset && (wake_done || (state_ff == ST_IDL && nxt_state == ST_RUN));
      isr_call_o     <= !any_reset && global_int_enable_i
                        && (wake_done || (state_ff == ST_IDL && wake_int));
      // Cleared on entry, on every sleep wake and through the start-up delay
      watchdog_clear_o <= any_reset || enter_sleep || state_ff == ST_WAKE
                          || (state_ff == ST_SLP && nxt_state != ST_SLP);
      watchdog_run_o   <= any_reset || (!(nxt_state == ST_SLP && !watchdog_in_sleep)
                          && nxt_state != ST_WAKE);
      sysclk_run_o     <= any_reset || nxt_state != ST_SLP;
      aux_osc_run_o    <= 1'b1;
      io_hold_o        <= !any_reset && (nxt_state == ST_SLP || nxt_state == ST_WAKE);
      sleep_mode_o     <= !any_reset && nxt_state == ST_SLP;
      idle_mode_o      <= !any_reset && nxt_state == ST_IDL;
      // Clock output is the system clock over four while the clock-out enable bit is clear; dead in Sleep
      if (state_ff != ST_SLP && !clock_out_enable)
      begin
        clock_output_pin_div_ff      <= clock_output_pin_div_ff + 2'b01;
        clock_output_pin_o <= clock_output_pin_div_ff[1];
      end
      else
      begin
        clock_output_pin_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### sleep_ctl_chk.sv
`default_nettype none
module sleep_ctl_chk (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic program_flash_ready_i,
  input wire logic sysclk_ready_i,
  input wire logic global_int_enable_i,
  input wire logic external_reset_pin_n_i,
  input wire logic resume_o,
  input wire logic isr_call_o,
  input wire logic device_reset_o,
  input wire logic watchdog_clear_o,
  input wire logic sysclk_run_o,
  input wire logic aux_osc_run_o,
  input wire logic io_hold_o,
  input wire logic cpu_step_o,
  input wire logic sleep_mode_o,
  input wire logic idle_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_sleep_halt: assert property (sleep_mode_o |-> !cpu_step_o && !sysclk_run_o)
    else $error("cpu or system clock running in sleep");
  a_sleep_hold: assert property (sleep_mode_o |-> io_hold_o && aux_osc_run_o)
    else $error("pins or oscillators released in sleep");
  a_idle_run: assert property (idle_mode_o |-> sysclk_run_o && !cpu_step_o && !sleep_mode_o)
    else $error("idle clocks wrong");
  a_entry_clear: assert property ($rose(sleep_mode_o) |-> watchdog_clear_o)
    else $error("watchdog not cleared on sleep entry");
  a_wake_clear: assert property ($fell(sleep_mode_o) && !device_reset_o |-> watchdog_clear_o)
    else $error("watchdog not cleared on wake");
  a_pin_reset: assert property (!external_reset_pin_n_i [*4] |-> device_reset_o)
    else $error("reset pin ignored");
  a_resume_ready: assert property (resume_o |-> $past(program_flash_ready_i) && $past(sysclk_ready_i))
    else $error("resume before ready");
  a_isr_gie: assert property (isr_call_o |-> global_int_enable_i)
    else $error("service call with interrupts off");
  a_bus_wait: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus wait cycle wrong");
  c_sleep_wake: cover property ($fell(sleep_mode_o));
  c_idle_wake: cover property ($fell(idle_mode_o));
  c_isr: cover property (isr_call_o);
endmodule
bind sleep_idle_doze_control sleep_ctl_chk chk (.*);
`default_nettype wire

// ### core_model.sv
`default_nettype none
module core_model #(
  parameter int RDY_DLY  = 20,
  parameter int EXIT_DLY = 50
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic sleep_mode_i,
  input  wire logic isr_call_i,
  output var  logic ready_o,
  output var  logic isr_entry_o,
  output var  logic isr_exit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int rdy_cnt;
  int isr_cnt;
  // Flash and clock come back slowly after sleep so the wake must wait
  always @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      rdy_cnt <= 0;
      isr_cnt <= 0;
      ready_o <= 1'b0;
      isr_entry_o <= 1'b0;
      isr_exit_o <= 1'b0;
    end
    else
    begin
      rdy_cnt <= sleep_mode_i ? RDY_DLY : (rdy_cnt > 0 ? rdy_cnt - 1 : 0);
      ready_o <= !sleep_mode_i && rdy_cnt == 0;
      isr_entry_o <= isr_call_i;
      isr_cnt <= isr_call_i ? EXIT_DLY : (isr_cnt > 0 ? isr_cnt - 1 : 0);
      isr_exit_o <= isr_cnt == 1;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`include "power_save_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CTL = `ADDR_SLOW_IDLE_CTRL;
  localparam logic [11:0] STA = `ADDR_POWER_STATUS;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [11:0] avs_address_i = 12'h000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic        sleep_exec_i = 1'b0;
  logic        global_int_enable_i = 1'b0;
  logic [7:0]  int_flags_i = 8'h00;
  logic [7:0]  periph_int_enable_regs_i = 8'h00;
  logic        external_reset_pin_n_i = 1'b1;
  logic        brownout_reset_i = 1'b0;
  logic        low_power_brownout_reset_i = 1'b0;
  logic        power_on_reset_i = 1'b0;
  logic        watchdog_timeout_i = 1'b0;
  logic        rdy;
  wire         isr_entry_i;
  wire         isr_exit_i;
  wire         program_flash_ready_i = rdy;
  wire         sysclk_ready_i = rdy;
  wire         brownout_ready_i = rdy;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, cpu_step_o, resume_o, isr_call_o, sleep_nop_o;
  wire         device_reset_o, watchdog_clear_o, watchdog_run_o, sysclk_run_o;
  wire         aux_osc_run_o, io_hold_o, clock_output_pin_o, sleep_mode_o, idle_mode_o;
  wire  [3:0]  ws = {resume_o, idle_mode_o, sleep_mode_o, device_reset_o};
  int          failures = 0;
  int          tests_run = 0;
  int          isr_n = 0;
  int          co_n = 0;
  logic        co_last = 1'b0;
  logic [7:0]  rq[$];
  logic [1:0]  eq[$];
  logic [31:0] lf = 32'h0001_3010;

  sleep_idle_doze_control dut (.*);
  core_model core (
    .clk_i        (ref_clk_i),
    .nrst_i       (nrst_i),
    .sleep_mode_i (sleep_mode_o),
    .isr_call_i   (isr_call_o),
    .ready_o      (rdy),
    .isr_entry_o  (isr_entry_i),
    .isr_exit_o   (isr_exit_i)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    chk("queues empty", 0, eq.size() + rq.size());
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    chk("wait bound", 0, 1);
    test_done();
  endtask
  task automatic bus(input logic rd, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk_i);
    lf = lfsr(lf);
    avs_address_i <= a;
    avs_writedata_i <= {lf[23:0], d};
    avs_read_i <= rd;
    avs_write_i <= !rd;
    n = 0;
    do
    begin
      @(negedge ref_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 50);
    @(posedge ref_clk_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50)
      hang();
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b1, a, 8'h00);
  endtask
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    while (ws[s] !== v && n < 3000)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 3000)
      hang();
  endtask
  task automatic slp();
    @(posedge ref_clk_i);
    sleep_exec_i <= 1'b1;
    @(posedge ref_clk_i);
    sleep_exec_i <= 1'b0;
  endtask

  initial
  begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Outputs are judged at the falling edge, clear of the launching edge
  always @(negedge ref_clk_i)
  begin
    if (avs_read_i && avs_waitrequest_o === 1'b0)
      chk("readdata", {24'h00_0000, rq.size() > 0 ? rq.pop_front() : 8'h00}, avs_readdata_o);
    if (resume_o !== 1'b0 || sleep_nop_o !== 1'b0)
      chk("event", eq.size() > 0 ? eq.pop_front() : 2'b00, {resume_o, sleep_nop_o});
    isr_n += (isr_call_o === 1'b1);
    co_n += (clock_output_pin_o !== co_last);
    co_last = clock_output_pin_o;
  end

  initial
  begin
    int b, n, k;
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(CTL, 8'h00);
    rd(`ADDR_WAKE_CFG, 8'h08);
    rd(STA, 8'h03);
    rd(12'h000, 8'h00);
    bus(1'b0, CTL, 8'hFF);
    rd(CTL, 8'hF7);
    bus(1'b0, CTL, 8'h00);
    bus(1'b0, `ADDR_WAKE_CFG, 8'h00);
    @(posedge ref_clk_i);
    int_flags_i <= 8'h01;
    periph_int_enable_regs_i <= 8'h01;
    eq.push_back(2'b01);
    slp();
    repeat (4) @(negedge ref_clk_i);
    chk("nop mode", 0, {sleep_mode_o, idle_mode_o});
    rd(STA, 8'h03);
    $display("test nop done");
    lf = lfsr(lf);
    b = (lf[2:0] == 3'd3) ? 5 : lf[2:0];
    @(posedge ref_clk_i);
    int_flags_i <= 8'h00;
    periph_int_enable_regs_i <= 8'h08;
    slp();
    wt(1, 1'b1);
    rd(STA, 8'h06);
    chk("watchdog run", 0, watchdog_run_o);
    @(posedge ref_clk_i);
    int_flags_i <= 8'h08 | (8'h01 << b);
    repeat (20) @(negedge ref_clk_i);
    chk("asleep", 1, sleep_mode_o);
    @(posedge ref_clk_i);
    periph_int_enable_regs_i <= 8'h08 | (8'h01 << b);
    eq.push_back(2'b10);
    wt(3, 1'b1);
    repeat (20) @(negedge ref_clk_i);
    chk("isr calls", 0, isr_n);
    rd(STA, 8'h02);
    $display("test sleep wake done");
    bus(1'b0, `ADDR_WAKE_CFG, 8'h04);
    bus(1'b0, CTL, 8'h70);
    @(posedge ref_clk_i);
    int_flags_i <= 8'h00;
    global_int_enable_i <= 1'b1;
    slp();
    wt(1, 1'b1);
    @(posedge ref_clk_i);
    int_flags_i <= 8'h01 << b;
    eq.push_back(2'b10);
    wt(1, 1'b0);
    n = 0;
    while (resume_o !== 1'b1 && n < 3000)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 3000)
      hang();
    chk("startup wait", 1, n >= 1024);
    repeat (20) @(negedge ref_clk_i);
    chk("isr calls", 1, isr_n);
    rd(CTL, 8'h30);
    repeat (70) @(negedge ref_clk_i);
    rd(CTL, 8'h70);
    $display("test service wake done");
    bus(1'b0, `ADDR_WAKE_CFG, 8'h00);
    bus(1'b0, CTL, 8'h80);
    for (k = 0; k < 2; k++)
    begin
      @(posedge ref_clk_i);
      global_int_enable_i <= 1'b0;
      int_flags_i <= 8'h00;
      slp();
      wt(2, 1'b1);
      n = co_n;
      repeat (16) @(negedge ref_clk_i);
      chk("clock out", 1, co_n > n);
      @(posedge ref_clk_i);
      watchdog_timeout_i <= (k == 0);
      int_flags_i <= (k == 1) ? 8'h01 << b : 8'h00;
      periph_int_enable_regs_i <= 8'hFF;
      eq.push_back(2'b10);
      @(posedge ref_clk_i);
      watchdog_timeout_i <= 1'b0;
      wt(2, 1'b0);
      repeat (10) @(negedge ref_clk_i);
      chk("no reset", 0, device_reset_o);
    end
    rd(CTL, 8'h80);
    $display("test idle done");
    for (k = 0; k < 8; k++)
    begin
      bus(1'b0, CTL, 8'h40 | k);
      repeat (4) @(negedge ref_clk_i);
      n = 0;
      repeat (8 << (k + 1))
      begin
        @(negedge ref_clk_i);
        n += (cpu_step_o === 1'b1);
      end
      chk("steps", 8, n);
    end
    bus(1'b0, CTL, 8'h00);
    $display("test ratio done");
    @(posedge ref_clk_i);
    int_flags_i <= 8'h00;
    external_reset_pin_n_i <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
    chk("pin reset", 1, device_reset_o);
    @(posedge ref_clk_i);
    external_reset_pin_n_i <= 1'b1;
    wt(0, 1'b0);
    slp();
    wt(1, 1'b1);
    @(posedge ref_clk_i);
    watchdog_timeout_i <= 1'b1;
    @(posedge ref_clk_i);
    watchdog_timeout_i <= 1'b0;
    wt(0, 1'b1);
    wt(0, 1'b0);
    rd(STA, 8'h01);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(CTL, 8'h00);
    $display("test resets done");
    test_done();
  end
endmodule
`default_nettype wire
